// [dps_pkg.sv]
// package of pin timing constants and request encodings for the dual-port ram host
package dps_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned ADDR_W         = 19;
   localparam int unsigned DATA_W         = 18;
   // =====================================================
   // timing figures in ns, slowest speed grade
   localparam int unsigned T_WC_NS        = 15;
   localparam int unsigned T_EW_NS        = 12;
   localparam int unsigned T_WP_NS        = 12;
   localparam int unsigned T_WZ_NS        = 8;
   localparam int unsigned T_DW_NS        = 10;
   localparam int unsigned T_RC_NS        = 15;
   localparam int unsigned T_ACC_NS       = 15;
   localparam int unsigned T_BDD_NS       = 15;
   localparam int unsigned T_HZ_NS        = 8;
   localparam int unsigned T_SWRD_NS      = 5;
   // =====================================================
   // derived cycle counts, minimums rounded up
   localparam int unsigned WC_CYC   = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_PLAIN = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_OE    = (T_WZ_NS + T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_CYC_OE = (WP_OE > WP_PLAIN) ? WP_OE : WP_PLAIN;
   localparam int unsigned RD_CYC   = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int unsigned RD_BDD_CYC = (T_ACC_NS + T_BDD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int unsigned HZ_CYC   = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SWRD_CYC = (T_SWRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W    = 4;
   // =====================================================
   // request kinds
   localparam logic [1:0] OP_READ      = 2'h0;
   localparam logic [1:0] OP_WRITE     = 2'h1;
   localparam logic [1:0] OP_SEMAPHORE_READ  = 2'h2;
   localparam logic [1:0] OP_SEMAPHORE_WRITE = 2'h3;
   typedef enum logic [2:0] {
      DPS_IDLE, DPS_SETUP, DPS_STROBE, DPS_RECOVER, DPS_READ, DPS_RELEASE
   } dps_state_t;
endpackage : dps_pkg

// [dps_sync.sv]
// two-flop synchroniser for the data pins coming back from the ram
`timescale 1ns/1ps
`default_nettype none
module dps_sync
   import dps_pkg::*;
#(
   parameter int unsigned W = 18
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s1_nxt;
   always_comb begin
      s1_nxt = d;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule // dps_sync
`default_nettype wire

// [dps_host.sv]
// host controller driving one port of an asynchronous dual-port static ram
// What this block does
// [RULE1] read data follows last asserted enable
// [RULE2] read data released on first deasserted enable
// [RULE3] sample read data after longest access delay
// [RULE4] conflict-release wait only when flagged by user
// [RULE5] conflict flag ignored for semaphore reads
// [RULE6] array uses chip select, semaphore uses semaphore select
// [RULE7] address changes only with strobe inactive, except in address-terminated writes
// [RULE8] array written during select, strobe, byte overlap
// [RULE9] last active control begins the write
// [RULE10] first inactive control ends the write
// [RULE11] data held past strobe deassertion
// [RULE12] selects asserted in the same cycle as the strobe keep outputs off
// [RULE13] longer strobe pulse while output enable on
// [RULE14] address-terminated writes keep controls active
// [RULE15] address change ends each streamed write
// [RULE16] each streamed address held one write cycle
// [RULE17] data pins stay input during streaming
// [RULE18] no setup or recovery between streamed writes
// [RULE19] streaming works with output enable off
// [RULE20] streamed writes repeat without limit
// [RULE21] chip select off through semaphore write/read
// [RULE22] semaphore read returns one value on all bits
// [RULE23] semaphore contention grants one port only
// [RULE24] combined select needs low and high select
// [RULE25] mode input picks strobe or address-terminated writes
`timescale 1ns/1ps
`default_nettype none
module dps_host
   import dps_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   // user side
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic [1:0]        req_op,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [1:0]        req_bytes,
   input  wire logic              req_conflict,
   input  wire logic              addr_term_mode,
   input  wire logic              oe_during_write,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   rsp_semaphore_state,
   // ram pins
   output logic [ADDR_W-1:0]      addr,
   output logic                   chip_select_active_low,
   output logic                   chip_select_active_high,
   output logic                   semaphore_select_n,
   output logic                   write_strobe_n,
   output logic                   output_enable_n,
   output logic                   upper_byte_select_n,
   output logic                   lower_byte_select_n,
   input  wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe
);
   // =====================================================
   // state
   dps_state_t        st_r, st_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic [1:0]        op_r, op_nxt;
   logic              stream_r, stream_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wd_r, wd_nxt;
   logic [1:0]        be_r, be_nxt;
   logic              cs_r, cs_nxt;
   logic              ssel_r, ssel_nxt;
   logic              we_r, we_nxt;
   logic              oe_r, oe_nxt;
   logic              doe_r, doe_nxt;
   logic              oew_r, oew_nxt;
   logic              rv_r, rv_nxt;
   logic [DATA_W-1:0] rd_r, rd_nxt;
   logic [DATA_W-1:0] din_s;
   logic              take;
   logic              is_semaphore;
   logic              is_wr;

   dps_sync #(.W(DATA_W)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (data_in),
      .q    (din_s)
   );

   assign is_semaphore = req_op[1];
   assign is_wr        = req_op[0];
   // streaming only accepts another array write at the ready cycle;
   // any other request waits for idle so that nothing is lost
   assign req_ready = (st_r == DPS_IDLE) ||
                      (st_r == DPS_STROBE && stream_r && cnt_r == '0 && req_op == OP_WRITE); // RULE14 RULE20
   assign take      = req_valid && req_ready;

   // =====================================================
   // next-state logic
   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      op_nxt     = op_r;
      stream_nxt = stream_r;
      addr_nxt   = addr_r;
      wd_nxt     = wd_r;
      be_nxt     = be_r;
      cs_nxt     = cs_r;
      ssel_nxt   = ssel_r;
      we_nxt     = we_r;
      oe_nxt     = oe_r;
      doe_nxt    = doe_r;
      oew_nxt    = oew_r;
      rv_nxt     = 1'b0;
      rd_nxt     = rd_r;
      if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
      case (st_r)
         DPS_IDLE: begin
            if (take) begin
               // address set while strobe and selects are off
               op_nxt   = req_op;
               addr_nxt = req_addr; // RULE7
               wd_nxt   = req_wdata;
               be_nxt   = is_semaphore ? 2'h3 : req_bytes;
               oew_nxt  = oe_during_write;
               stream_nxt = addr_term_mode && !is_semaphore && is_wr; // RULE25
               st_nxt   = DPS_SETUP;
            end
         end
         DPS_SETUP: begin
            // select asserted in the same cycle as the strobe so ram outputs stay off
            cs_nxt   = !op_r[1]; // RULE6 RULE24
            ssel_nxt = op_r[1];  // RULE6 RULE21
            if (op_r[0]) begin
               we_nxt  = 1'b1; // RULE9 RULE12
               oe_nxt  = oew_r;
               doe_nxt = 1'b1;
               cnt_nxt = CNT_W'(((oew_r ? WP_CYC_OE : WP_PLAIN) > WC_CYC ?
                         (oew_r ? WP_CYC_OE : WP_PLAIN) : WC_CYC) - 1); // RULE13 RULE16
               st_nxt  = DPS_STROBE;
            end else begin
               oe_nxt  = 1'b1; // RULE1
               cnt_nxt = CNT_W'((op_r[1] ? RD_CYC + SWRD_CYC :
                         (req_conflict ? RD_BDD_CYC : RD_CYC)) - 1); // RULE3 RULE4 RULE5
               st_nxt  = DPS_READ;
            end
         end
         DPS_STROBE: begin
            if (cnt_r == '0) begin
               if (stream_r && take && req_op == OP_WRITE) begin
                  // address change ends this write; controls stay active
                  addr_nxt = req_addr; // RULE15 RULE17 RULE18 RULE19
                  wd_nxt   = req_wdata; // RULE16
                  be_nxt   = req_bytes;
                  cnt_nxt  = CNT_W'(WC_CYC - 1);
               end else begin
                  // output enable drops with the strobe: the ram must not drive into held data
                  we_nxt  = 1'b0; // RULE10 RULE8
                  oe_nxt  = 1'b0; // RULE11
                  cnt_nxt = CNT_W'(1);
                  st_nxt  = DPS_RECOVER;
               end
            end
         end
         DPS_RECOVER: begin
            // data held two cycles past strobe release
            if (cnt_r == CNT_W'(1)) begin
               cs_nxt   = 1'b0; // RULE11
               ssel_nxt = 1'b0;
               oe_nxt   = 1'b0;
               be_nxt   = 2'h0;
            end
            if (cnt_r == '0) begin
               doe_nxt = 1'b0;
               stream_nxt = 1'b0;
               st_nxt = DPS_IDLE;
            end
         end
         DPS_READ: begin
            if (cnt_r == '0) begin
               // semaphore value mirrored on every bit
               rd_nxt = din_s; // RULE22 RULE23
               rv_nxt = 1'b1;
               oe_nxt   = 1'b0; // RULE2
               cs_nxt   = 1'b0;
               ssel_nxt = 1'b0;
               be_nxt   = 2'h0;
               cnt_nxt = CNT_W'(HZ_CYC);
               st_nxt = DPS_RELEASE;
            end
         end
         DPS_RELEASE: begin
            if (cnt_r == '0) st_nxt = DPS_IDLE;
         end
         default: st_nxt = DPS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r     <= DPS_IDLE;
         cnt_r    <= '0;
         op_r     <= OP_READ;
         stream_r <= 1'b0;
         addr_r   <= '0;
         wd_r     <= '0;
         be_r     <= 2'h0;
         cs_r     <= 1'b0;
         ssel_r   <= 1'b0;
         we_r     <= 1'b0;
         oe_r     <= 1'b0;
         doe_r    <= 1'b0;
         oew_r    <= 1'b0;
         rv_r     <= 1'b0;
         rd_r     <= '0;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         op_r     <= op_nxt;
         stream_r <= stream_nxt;
         addr_r   <= addr_nxt;
         wd_r     <= wd_nxt;
         be_r     <= be_nxt;
         cs_r     <= cs_nxt;
         ssel_r   <= ssel_nxt;
         we_r     <= we_nxt;
         oe_r     <= oe_nxt;
         doe_r    <= doe_nxt;
         oew_r    <= oew_nxt;
         rv_r     <= rv_nxt;
         rd_r     <= rd_nxt;
      end
   end

   // =====================================================
   // pin drive
   assign addr                    = addr_r;
   assign chip_select_active_low  = !cs_r;
   assign chip_select_active_high = cs_r;
   assign semaphore_select_n      = !ssel_r;
   assign write_strobe_n          = !we_r;
   assign output_enable_n         = !oe_r;
   assign upper_byte_select_n     = !be_r[1];
   assign lower_byte_select_n     = !be_r[0];
   assign data_out                = wd_r;
   assign data_oe                 = doe_r;
   assign rsp_valid               = rv_r;
   assign rsp_rdata               = rd_r;
   assign rsp_semaphore_state     = rd_r[0];
endmodule // dps_host
`default_nettype wire

// [dps_host_sva.sv]
// pin timing assertions for the dual-port ram host
`timescale 1ns/1ps
`default_nettype none
module dps_host_sva
   import dps_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              chip_select_active_low,
   input wire logic              chip_select_active_high,
   input wire logic              semaphore_select_n,
   input wire logic              write_strobe_n,
   input wire logic              output_enable_n,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe,
   input wire logic              addr_term_mode,
   input wire logic              oe_during_write
);
   wire logic cs = !chip_select_active_low && chip_select_active_high;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // strobe and select relations
   chk_sel_excl: assert property (cs |-> semaphore_select_n) else $error("both selects on");
   chk_addr_hold: assert property (!write_strobe_n && $past(!write_strobe_n) && !addr_term_mode |-> $stable(addr))
      else $error("address moved in write");
   chk_strobe_end: assert property ($rose(write_strobe_n) |-> cs || !semaphore_select_n) else $error("select off early");
   chk_data_hold: assert property ($rose(write_strobe_n) |-> data_oe && $stable(data_out)) else $error("data not held");
   chk_strobe_wide: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*2]) else $error("short strobe");
   chk_wr_drive: assert property (!write_strobe_n |-> data_oe) else $error("data not driven");
   chk_oe_off: assert property (!write_strobe_n && !oe_during_write |-> output_enable_n) else $error("oe on in write");
   // host must never fight the ram's read drivers
   chk_rd_nodrive: assert property (!output_enable_n && write_strobe_n |-> !data_oe) else $error("bus fight");
endmodule // dps_host_sva
bind dps_host dps_host_sva u_sva (
   .clk                     (clk),
   .rstn                    (rstn),
   .addr                    (addr),
   .chip_select_active_low  (chip_select_active_low),
   .chip_select_active_high (chip_select_active_high),
   .semaphore_select_n      (semaphore_select_n),
   .write_strobe_n          (write_strobe_n),
   .output_enable_n         (output_enable_n),
   .data_out                (data_out),
   .data_oe                 (data_oe),
   .addr_term_mode          (addr_term_mode),
   .oe_during_write         (oe_during_write)
);
`default_nettype wire

// [dps_ram_model.sv]
// behavioural model of one port of the dual-port ram
`timescale 1ns/1ps
`default_nettype none
module dps_ram_model
   import dps_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              chip_select_active_low,
   input  wire logic              chip_select_active_high,
   input  wire logic              semaphore_select_n,
   input  wire logic              write_strobe_n,
   input  wire logic              output_enable_n,
   input  wire logic              upper_byte_select_n,
   input  wire logic              lower_byte_select_n,
   input  wire logic [DATA_W-1:0] data_out,
   output logic      [DATA_W-1:0] data_in
);
   // only the low address bits decode, enough for the bench
   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] last = '0;
   logic              flag = 1'b1;
   wire logic         cs = !chip_select_active_low && chip_select_active_high;
   wire logic         wr = cs && semaphore_select_n && !write_strobe_n;
   always @(wr, addr, data_out, upper_byte_select_n, lower_byte_select_n) begin
      // address and data move on the same host edge; let both settle first
      #1;
      if (wr && !upper_byte_select_n) mem[addr[3:0]][17:9] = data_out[17:9];
      if (wr && !lower_byte_select_n) mem[addr[3:0]][8:0] = data_out[8:0];
   end
   // single port here, so a contended flag always lands on this side
   always @(cs, semaphore_select_n, write_strobe_n, data_out) begin
      if (!cs && !semaphore_select_n && !write_strobe_n) flag = data_out[0];
   end
   always @* begin
      if (write_strobe_n && !output_enable_n && (!semaphore_select_n && !cs
          || cs && semaphore_select_n && !(upper_byte_select_n && lower_byte_select_n))) begin
         data_in = !semaphore_select_n ? {DATA_W{flag}} : mem[addr[3:0]];
         last = data_in;
      end
      else data_in = ~last;
   end
endmodule // dps_ram_model
`default_nettype wire

// [tb_dps_host.sv]
// testbench for the dual-port ram host
`timescale 1ns/1ps
`default_nettype none
module tb_dps_host
   import dps_pkg::*;
;
   logic              clk = 1'b0;
   logic              rstn, req_valid, req_ready, req_conflict, addr_term_mode, oe_during_write;
   logic              rsp_valid, rsp_semaphore_state, data_oe, write_strobe_n, semaphore_select_n;
   logic              chip_select_active_low, chip_select_active_high, output_enable_n;
   logic              upper_byte_select_n, lower_byte_select_n;
   logic [1:0]        req_op, req_bytes;
   logic [ADDR_W-1:0] req_addr, addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, data_in, data_out, q;
   int                fail_count = 0, num_checks = 0, rises = 0, r0, lat;
   dps_host DUT (
      .clk                     (clk),
      .rstn                    (rstn),
      .req_valid               (req_valid),
      .req_ready               (req_ready),
      .req_op                  (req_op),
      .req_addr                (req_addr),
      .req_wdata               (req_wdata),
      .req_bytes               (req_bytes),
      .req_conflict            (req_conflict),
      .addr_term_mode          (addr_term_mode),
      .oe_during_write         (oe_during_write),
      .rsp_valid               (rsp_valid),
      .rsp_rdata               (rsp_rdata),
      .rsp_semaphore_state     (rsp_semaphore_state),
      .addr                    (addr),
      .chip_select_active_low  (chip_select_active_low),
      .chip_select_active_high (chip_select_active_high),
      .semaphore_select_n      (semaphore_select_n),
      .write_strobe_n          (write_strobe_n),
      .output_enable_n         (output_enable_n),
      .upper_byte_select_n     (upper_byte_select_n),
      .lower_byte_select_n     (lower_byte_select_n),
      .data_in                 (data_in),
      .data_out                (data_out),
      .data_oe                 (data_oe)
   );
   dps_ram_model u_ram (
      .addr                    (addr),
      .chip_select_active_low  (chip_select_active_low),
      .chip_select_active_high (chip_select_active_high),
      .semaphore_select_n      (semaphore_select_n),
      .write_strobe_n          (write_strobe_n),
      .output_enable_n         (output_enable_n),
      .upper_byte_select_n     (upper_byte_select_n),
      .lower_byte_select_n     (lower_byte_select_n),
      .data_out                (data_out),
      .data_in                 (data_in)
   );
   always #5 clk = ~clk;
   always @(posedge write_strobe_n) rises++;
   // ==========
   // shared tasks
   task automatic check(input logic [DATA_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic go(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [1:0] b);
      int n = 0;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_bytes <= b;
      req_valid <= 1'b1;
      do @(negedge clk); while (req_ready !== 1'b1 && n++ < 50);
      if (req_ready !== 1'b1) fail_count++;
      @(posedge clk);
   endtask
   task automatic wr(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [1:0] b);
      go(op, a, d, b);
      req_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [1:0] op, input logic [ADDR_W-1:0] a);
      int n = 0;
      go(op, a, '0, 2'h3);
      req_valid <= 1'b0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && n++ < 60);
      if (rsp_valid !== 1'b1) fail_count++;
      lat = n;
      q = rsp_rdata;
      @(posedge clk);
   endtask
   // ==========
   // scenarios
   task automatic t_plain();
      for (int o = 0; o < 2; o++) begin
         oe_during_write <= o[0];
         r0 = rises;
         wr(OP_WRITE, ADDR_W'(5 + o), DATA_W'(18'h2a5a5 + o), 2'h3);
         rd(OP_READ, ADDR_W'(5 + o));
         check(q, DATA_W'(18'h2a5a5 + o));
         check(DATA_W'(rises - r0), 18'h1);
      end
      oe_during_write <= 1'b0;
   endtask
   task automatic t_bytes();
      wr(OP_WRITE, 19'h2, 18'h3ffff, 2'h3);
      wr(OP_WRITE, 19'h2, 18'h0, 2'h2);
      rd(OP_READ, 19'h2);
      check(q, 18'h001ff);
   endtask
   task automatic t_stream();
      addr_term_mode <= 1'b1;
      r0 = rises;
      for (int i = 0; i < 3; i++) go(OP_WRITE, ADDR_W'(8 + i), DATA_W'(18'h11 * (i + 1)), 2'h3);
      req_valid <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         rd(OP_READ, ADDR_W'(8 + i));
         check(q, DATA_W'(18'h11 * (i + 1)));
      end
      check(DATA_W'(rises - r0), 18'h1);
      addr_term_mode <= 1'b0;
   endtask
   task automatic t_semaphore();
      for (int v = 0; v < 2; v++) begin
         wr(OP_SEMAPHORE_WRITE, 19'h0, {DATA_W{v[0]}}, 2'h3);
         rd(OP_SEMAPHORE_READ, 19'h0);
         check(q, {DATA_W{v[0]}});
         check(DATA_W'(rsp_semaphore_state), DATA_W'(v[0]));
      end
   endtask
   task automatic t_conflict();
      rd(OP_READ, 19'h9);
      check(q, 18'h22);
      r0 = lat;
      req_conflict <= 1'b1;
      rd(OP_READ, 19'h8);
      check(q, 18'h11);
      check(DATA_W'(lat - r0), DATA_W'(RD_BDD_CYC - RD_CYC));
      req_conflict <= 1'b0;
   endtask
   initial begin
      rstn = 1'b0;
      {req_valid, req_conflict, addr_term_mode, oe_during_write} = 4'h0;
      {req_op, req_bytes} = 4'h0;
      req_addr = '0;
      req_wdata = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      check({write_strobe_n, data_oe}, 18'h2);
      @(posedge clk);
      t_plain();
      t_bytes();
      t_stream();
      t_semaphore();
      t_conflict();
      results();
   end
   // the whole run needs under two thousand ns
   initial begin
      #50000;
      fail_count++;
      results();
   end
endmodule // tb_dps_host
`default_nettype wire
